// >>> hw/dtrfe_map.vh
// register map, field positions and fixed counts of the request front end
`ifndef DTRFE_MAP_VH
`define DTRFE_MAP_VH
`define DTRFE_CPU_PER_ENGINE  2
`define DTRFE_BYTES_PER_CYCLE 8
`define DTRFE_QUEUE_DEPTH     16
`define DTRFE_NUM_QUEUES      4
`define DTRFE_NUM_CHANNELS    64
`define DTRFE_OFF_CACHE_CFG   12'h000
`define DTRFE_OFF_QC_OPT      12'h004
`define DTRFE_OFF_MASTER_CTL  12'h008
`define DTRFE_OFF_WEIGHT      12'h00c
`define DTRFE_OFF_STATUS      12'h010
`define DTRFE_RAM_SEL         2'h1
`define DTRFE_RST_CTL         2'h0
`define DTRFE_CTL_CNT_MSB     15
`define DTRFE_CTL_SYNC_MSB    19
`define DTRFE_CTL_SYNC_LSB    16
`define DTRFE_CTL_PRI_MSB     21
`define DTRFE_CTL_PRI_LSB     20
`define DTRFE_CTL_LINK_MSB    29
`define DTRFE_CTL_LINK_LSB    24
`define DTRFE_CTL_LINK_EN     31
`define DTRFE_KIND_QCOPY      3'h0
`define DTRFE_KIND_NONCACHE   3'h1
`define DTRFE_KIND_ALLOC      3'h2
`define DTRFE_KIND_EVICT      3'h3
`define DTRFE_KIND_USEROP     3'h4
`define DTRFE_KIND_L2SRAM     3'h5
`define DTRFE_KIND_CFGREG     3'h6
`define DTRFE_KIND_CACHED     3'h7
`define DTRFE_ORG_CACHE       2'h0
`define DTRFE_ORG_CHAN        2'h1
`define DTRFE_ORG_MASTER      2'h2
`endif

// >>> hw/dtrfe_ram.v
// simple dual-port memory with registered read data
module dtrfe_ram #(
    parameter W  = 32,
    parameter AW = 8
) (
    input  wire          clk,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [W-1:0]  wdata,
    input  wire [AW-1:0] raddr,
    output reg  [W-1:0]  rdata
);
    reg [W-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // dtrfe_ram

// >>> hw/dtrfe_top.v
// transfer request front end: requestors, arbitration and priority queues
`include "dtrfe_map.vh"

module dtrfe_top #(
    parameter QDEPTH = `DTRFE_QUEUE_DEPTH,
    parameter QAW    = 4
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        cache_req_valid,
    input  wire [2:0]  cache_req_kind,
    input  wire [31:0] cache_req_src,
    input  wire [31:0] cache_req_dst,
    input  wire [15:0] cache_req_cnt,
    output reg         cache_req_ready,
    output reg         route_dma,
    output reg         route_l2,
    output reg         route_cfg,
    input  wire        l2_req_cpu,
    input  wire        l2_req_dma,
    output reg         l2_grant_cpu,
    output reg         l2_grant_dma,
    input  wire [63:0] chan_event,
    input  wire        master_req_valid,
    input  wire [31:0] master_req_src,
    input  wire [31:0] master_req_dst,
    input  wire [15:0] master_req_cnt,
    output reg         master_req_ready,
    output reg         mc_valid,
    input  wire        mc_ready,
    output reg  [1:0]  mc_pri,
    output reg  [1:0]  mc_origin,
    output reg  [31:0] mc_src,
    output reg  [31:0] mc_dst,
    output reg  [15:0] mc_cnt,
    output reg  [13:0] mc_beats
);
    localparam CH_IDLE = 2'd0, CH_READ = 2'd1, CH_ISSUE = 2'd2, CH_LINK = 2'd3;

    // lowest set bit of the pending events, fixed channel order
    function [6:0] first_set;
        input [63:0] v;
        integer i;
        begin
            first_set = 7'h40;
            for (i = 63; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    first_set = i[6:0];
                end
            end
        end
    endfunction

    // winner among holders: strict less keeps the earlier origin on a tie
    function [2:0] pick;
        input [2:0] v;
        input [5:0] p;
        integer i;
        reg [1:0] bp;
        begin
            pick = 3'h4;
            bp = 2'h3;
            for (i = 0; i < 3; i = i + 1) begin
                if (v[i] && (pick[2] || p[2*i +: 2] < bp)) begin
                    pick = i[2:0];
                    bp = p[2*i +: 2];
                end
            end
        end
    endfunction

    // beats of the eight byte datapath, rounded up
    function [13:0] beats;
        input [15:0] c;
        reg [16:0] s;
        begin
            s = {1'b0, c} + 17'h00007;
            beats = s[16:3];
        end
    endfunction

    reg         tick_reg;
    reg [1:0]   cache_pri_reg, qc_pri_reg, master_pri_reg;
    reg         weight_reg;
    reg         apb_stage_reg;
    reg [2:0]   hold_v_reg;
    reg [79:0]  hold_d_reg [0:2];
    reg [1:0]   hold_p_reg [0:2];
    reg [QAW:0] q_cnt_reg [0:3];
    reg [QAW-1:0] q_wr_reg [0:3];
    reg [QAW-1:0] q_rd_reg [0:3];
    reg [1:0]   deq_phase_reg, deq_q_reg;
    reg [63:0]  pend_reg;
    reg [1:0]   ch_state_reg;
    reg [5:0]   ch_reg;
    reg [2:0]   ch_k_reg;
    reg [31:0]  ch_src_reg, ch_dst_reg, ch_ctl_reg;
    integer     n;

    wire        ram_sel  = psel && (paddr[11:10] == `DTRFE_RAM_SEL);
    wire        apb_act  = psel && penable && !pready;
    wire        apb_own  = ram_sel && (ch_state_reg == CH_IDLE);
    wire [6:0]  ch_first = first_set(pend_reg);
    wire [2:0]  win      = pick(hold_v_reg, {hold_p_reg[2], hold_p_reg[1], hold_p_reg[0]});
    wire [1:0]  win_q    = hold_p_reg[win[1:0]];
    wire        enq      = tick_reg && !win[2] && (q_cnt_reg[win_q] != QDEPTH);
    wire [31:0] ram_rdata;
    wire [81:0] q_rdata;
    wire        q_any = (q_cnt_reg[0] != 0) || (q_cnt_reg[1] != 0) ||
                        (q_cnt_reg[2] != 0) || (q_cnt_reg[3] != 0);
    wire [1:0]  q_head = (q_cnt_reg[0] != 0) ? 2'd0 : (q_cnt_reg[1] != 0) ? 2'd1 :
                         (q_cnt_reg[2] != 0) ? 2'd2 : 2'd3;
    wire        deq = tick_reg && (deq_phase_reg == 2'd0) && q_any && !mc_valid;
    wire [3:0]  ch_sync = ch_ctl_reg[`DTRFE_CTL_SYNC_MSB:`DTRFE_CTL_SYNC_LSB];
    wire [3:0]  sync_left = (ch_sync == 4'h0) ? 4'h0 : ch_sync - 4'h1;
    wire [5:0]  ch_link = ch_ctl_reg[`DTRFE_CTL_LINK_MSB:`DTRFE_CTL_LINK_LSB];
    wire        ch_go = tick_reg && (ch_state_reg == CH_IDLE) && !ch_first[6] && !ram_sel;
    wire        ch_load = tick_reg && (ch_state_reg == CH_ISSUE) && !hold_v_reg[1];
    wire        cache_take = cache_req_valid && cache_req_ready;
    wire        cache_dma = (cache_req_kind <= `DTRFE_KIND_USEROP);

    // setting ram ports: the channel walker owns them unless idle
    reg         ram_we;
    reg [7:0]   ram_waddr, ram_raddr;
    reg [31:0]  ram_wdata;
    always @* begin
        ram_we    = 1'b0;
        ram_waddr = {ch_reg, 2'd2};
        ram_wdata = {ch_ctl_reg[31:20], sync_left, ch_ctl_reg[15:0]};
        ram_raddr = {ch_reg, ch_k_reg[1:0]};
        if (apb_own) begin
            ram_we    = apb_act && pwrite;
            ram_waddr = paddr[9:2];
            ram_wdata = pwdata;
            ram_raddr = paddr[9:2];
        end else if (ch_state_reg == CH_LINK) begin
            // link reload copy
            // read data trails the address by one cpu clock, half a tick, so word k lands at step k
            ram_we    = tick_reg && (ch_k_reg != 3'd3);
            ram_waddr = {ch_reg, ch_k_reg[1:0]};
            ram_wdata = ram_rdata;
            ram_raddr = {ch_link, ch_k_reg[1:0]};
        end else if (ch_state_reg == CH_ISSUE) begin
            ram_we    = ch_load;
        end
    end

    dtrfe_ram #(.W(32), .AW(8)) u_setting_ram (
        .clk   (pclk),
        .we    (ram_we),
        .waddr (ram_waddr),
        .wdata (ram_wdata),
        .raddr (ram_raddr),
        .rdata (ram_rdata)
    );

    // four queues of depth entries in one memory
    dtrfe_ram #(.W(82), .AW(QAW + 2)) u_queue_ram (
        .clk   (pclk),
        .we    (enq),
        .waddr ({win_q, q_wr_reg[win_q]}),
        .wdata ({win[1:0], hold_d_reg[win[1:0]]}),
        .raddr ({deq_q_reg, q_rd_reg[deq_q_reg]}),
        .rdata (q_rdata)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_reg        <= 1'b0;
            cache_pri_reg   <= `DTRFE_RST_CTL;
            qc_pri_reg      <= `DTRFE_RST_CTL;
            master_pri_reg  <= `DTRFE_RST_CTL;
            weight_reg      <= 1'b0;
            apb_stage_reg   <= 1'b0;
            prdata          <= 32'h0;
            pready          <= 1'b0;
            pslverr         <= 1'b0;
            cache_req_ready <= 1'b0;
            master_req_ready <= 1'b0;
            route_dma       <= 1'b0;
            route_l2        <= 1'b0;
            route_cfg       <= 1'b0;
            l2_grant_cpu    <= 1'b0;
            l2_grant_dma    <= 1'b0;
            hold_v_reg      <= 3'h0;
            deq_phase_reg   <= 2'd0;
            deq_q_reg       <= 2'd0;
            pend_reg        <= 64'h0;
            ch_state_reg    <= CH_IDLE;
            ch_reg          <= 6'h0;
            ch_k_reg        <= 3'h0;
            ch_src_reg      <= 32'h0;
            ch_dst_reg      <= 32'h0;
            ch_ctl_reg      <= 32'h0;
            mc_valid        <= 1'b0;
            mc_pri          <= 2'h0;
            mc_origin       <= 2'h0;
            mc_src          <= 32'h0;
            mc_dst          <= 32'h0;
            mc_cnt          <= 16'h0;
            mc_beats        <= 14'h0;
            for (n = 0; n < 4; n = n + 1) begin
                q_cnt_reg[n] <= {(QAW+1){1'b0}};
                q_wr_reg[n]  <= {QAW{1'b0}};
                q_rd_reg[n]  <= {QAW{1'b0}};
            end
            for (n = 0; n < 3; n = n + 1) begin
                hold_d_reg[n] <= 80'h0;
                hold_p_reg[n] <= 2'h0;
            end
        end else begin
            // engine rate is half the cpu clock
            tick_reg <= !tick_reg;
            pready   <= 1'b0;
            // apb slave: registers answer in one wait, ram reads in two
            if (apb_act && ram_sel) begin
                if (apb_own && (pwrite || apb_stage_reg)) begin
                    pready        <= 1'b1;
                    prdata        <= pwrite ? 32'h0 : ram_rdata;
                    apb_stage_reg <= 1'b0;
                end else if (apb_own) begin
                    apb_stage_reg <= 1'b1;
                end
            end else if (apb_act) begin
                pready <= 1'b1;
                prdata <= 32'h0;
                if (pwrite) begin
                    if (paddr == `DTRFE_OFF_CACHE_CFG) begin
                        cache_pri_reg <= pwdata[1:0];
                    end else if (paddr == `DTRFE_OFF_QC_OPT) begin
                        qc_pri_reg <= pwdata[1:0];
                    end else if (paddr == `DTRFE_OFF_MASTER_CTL) begin
                        master_pri_reg <= pwdata[1:0];
                    end else if (paddr == `DTRFE_OFF_WEIGHT) begin
                        weight_reg <= pwdata[0];
                    end
                end else if (paddr == `DTRFE_OFF_CACHE_CFG) begin
                    prdata <= {30'h0, cache_pri_reg};
                end else if (paddr == `DTRFE_OFF_QC_OPT) begin
                    prdata <= {30'h0, qc_pri_reg};
                end else if (paddr == `DTRFE_OFF_MASTER_CTL) begin
                    prdata <= {30'h0, master_pri_reg};
                end else if (paddr == `DTRFE_OFF_WEIGHT) begin
                    prdata <= {31'h0, weight_reg};
                end else if (paddr == `DTRFE_OFF_STATUS) begin
                    prdata <= {10'h0, !ch_first[6], ch_state_reg != CH_IDLE,
                               q_cnt_reg[3], q_cnt_reg[2], q_cnt_reg[1], q_cnt_reg[0]};
                end
            end
            l2_grant_cpu <= l2_req_cpu && !(l2_req_dma && weight_reg);
            l2_grant_dma <= l2_req_dma && !(l2_req_cpu && !weight_reg);
            // routing of every accepted cache access
            route_dma <= cache_take && cache_dma;
            route_l2  <= cache_take && (cache_req_kind == `DTRFE_KIND_L2SRAM ||
                                        cache_req_kind == `DTRFE_KIND_CACHED);
            route_cfg <= cache_take && (cache_req_kind == `DTRFE_KIND_CFGREG);
            // the five cases load a request; the rest load none
            if (cache_take && cache_dma) begin
                hold_v_reg[0] <= 1'b1;
                hold_d_reg[0] <= {cache_req_cnt, cache_req_dst, cache_req_src};
                // quick copy priority; otherwise cache config priority
                hold_p_reg[0] <= (cache_req_kind == `DTRFE_KIND_QCOPY) ? qc_pri_reg
                                                                        : cache_pri_reg;
            end
            // master requests enter directly at master priority
            if (master_req_valid && master_req_ready) begin
                hold_v_reg[2] <= 1'b1;
                hold_d_reg[2] <= {master_req_cnt, master_req_dst, master_req_src};
                hold_p_reg[2] <= master_pri_reg;
            end
            // one request per event, written back with one sync spent
            if (ch_load) begin
                hold_v_reg[1] <= 1'b1;
                hold_d_reg[1] <= {ch_ctl_reg[`DTRFE_CTL_CNT_MSB:0], ch_dst_reg, ch_src_reg};
                hold_p_reg[1] <= ch_ctl_reg[`DTRFE_CTL_PRI_MSB:`DTRFE_CTL_PRI_LSB];
            end
            // highest priority holder enqueues, one origin-blind path
            if (enq) begin
                hold_v_reg[win[1:0]] <= 1'b0;
                q_wr_reg[win_q]      <= q_wr_reg[win_q] + 1'b1;
            end
            cache_req_ready  <= !hold_v_reg[0] && !cache_take &&
                                !(enq && win[1:0] == 2'd0 && 1'b0);
            master_req_ready <= !hold_v_reg[2] && !(master_req_valid && master_req_ready);
            for (n = 0; n < 4; n = n + 1) begin
                q_cnt_reg[n] <= q_cnt_reg[n] + ((enq && win_q == n) ? 1'b1 : 1'b0)
                                             - ((deq && q_head == n) ? 1'b1 : 1'b0);
            end
            // queue head moves into the controller registers
            // head out two ticks after dequeue
            if (deq) begin
                deq_q_reg     <= q_head;
                deq_phase_reg <= 2'd1;
            end else if (tick_reg && deq_phase_reg == 2'd1) begin
                deq_phase_reg <= 2'd2;
            end else if (tick_reg && deq_phase_reg == 2'd2) begin
                deq_phase_reg       <= 2'd0;
                q_rd_reg[deq_q_reg] <= q_rd_reg[deq_q_reg] + 1'b1;
                mc_valid  <= 1'b1;
                mc_pri    <= deq_q_reg;
                mc_origin <= q_rdata[81:80];
                mc_src    <= q_rdata[31:0];
                mc_dst    <= q_rdata[63:32];
                mc_cnt    <= q_rdata[79:64];
                // beat count of the eight byte path
                mc_beats  <= beats(q_rdata[79:64]);
            end else if (mc_valid && mc_ready) begin
                mc_valid <= 1'b0;
            end
            // events set pending; a new event beats the clear of its bit
            pend_reg <= (pend_reg & ~(ch_go ? (64'h1 << ch_first[5:0]) : 64'h0))
                        | chan_event;
            case (ch_state_reg)
                CH_IDLE: begin
                    if (ch_go) begin
                        ch_reg       <= ch_first[5:0];
                        ch_k_reg     <= 3'd0;
                        ch_state_reg <= CH_READ;
                    end
                end
                CH_READ: begin
                    if (tick_reg) begin
                        ch_k_reg <= ch_k_reg + 3'd1;
                        // word k stands on the read port at step k
                        if (ch_k_reg == 3'd0) begin
                            ch_src_reg <= ram_rdata;
                        end else if (ch_k_reg == 3'd1) begin
                            ch_dst_reg <= ram_rdata;
                        end else if (ch_k_reg == 3'd2) begin
                            ch_ctl_reg   <= ram_rdata;
                            ch_state_reg <= CH_ISSUE;
                        end
                    end
                end
                CH_ISSUE: begin
                    if (ch_load) begin
                        ch_k_reg <= 3'd0;
                        // reload only once the set is exhausted
                        if (sync_left == 4'h0 && ch_ctl_reg[`DTRFE_CTL_LINK_EN]) begin
                            ch_state_reg <= CH_LINK;
                        end else begin
                            ch_state_reg <= CH_IDLE;
                        end
                    end
                end
                default: begin
                    if (tick_reg) begin
                        ch_k_reg <= ch_k_reg + 3'd1;
                        if (ch_k_reg == 3'd3) begin
                            ch_state_reg <= CH_IDLE;
                        end
                    end
                end
            endcase
        end
    end
endmodule // dtrfe_top

// >>> tb/dtrfe_top_sva.sv
// concurrent checks on the request front end ports
module dtrfe_top_sva #(
    parameter QDEPTH = 16
) (
    input logic        pclk,
    input logic        presetn,
    input logic        cache_req_valid,
    input logic        cache_req_ready,
    input logic [2:0]  cache_req_kind,
    input logic        route_dma,
    input logic        route_l2,
    input logic        route_cfg,
    input logic        l2_req_cpu,
    input logic        l2_req_dma,
    input logic        l2_grant_cpu,
    input logic        l2_grant_dma,
    input logic        mc_valid,
    input logic        mc_ready,
    input logic [1:0]  mc_origin,
    input logic [31:0] mc_src,
    input logic [15:0] mc_cnt,
    input logic [13:0] mc_beats
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic        take;
    logic [16:0] beats_exp;
    assign take = cache_req_valid && cache_req_ready;
    // beats are whole eight-byte moves, so a partial word rounds up
    assign beats_exp = ({1'b0, mc_cnt} + 17'h7) >> 3;
    a_route_dma: assert property (take && cache_req_kind <= 3'h4 |=> route_dma && !route_l2 && !route_cfg)
        else $error("dma kind not routed to engine");
    a_route_cfg: assert property (take && cache_req_kind == 3'h6 |=> route_cfg && !route_dma)
        else $error("config access not routed to config bus");
    a_no_request: assert property (take && (cache_req_kind == 3'h5 || cache_req_kind == 3'h7)
        |=> route_l2 && !route_dma)
        else $error("local access routed to engine");
    a_take_drops: assert property (take |=> !cache_req_ready)
        else $error("ready stayed high after a take");
    a_grant_excl: assert property (!(l2_grant_cpu && l2_grant_dma))
        else $error("both sides granted");
    a_grant_lone: assert property (l2_req_cpu && !l2_req_dma |=> l2_grant_cpu)
        else $error("lone cpu request not granted");
    a_head_hold: assert property (mc_valid && !mc_ready |=> mc_valid && $stable(mc_src) && $stable(mc_cnt))
        else $error("head changed while stalled");
    a_head_drop: assert property (mc_valid && mc_ready |=> !mc_valid)
        else $error("head stayed after handshake");
    a_beats_calc: assert property (mc_valid |-> mc_beats == beats_exp[13:0])
        else $error("beat count wrong");
    a_origin_ok: assert property (mc_valid |-> mc_origin != 2'h3)
        else $error("unknown origin code");
endmodule // dtrfe_top_sva
bind dtrfe_top dtrfe_top_sva #(.QDEPTH(QDEPTH)) u_dtrfe_top_sva (
    .pclk, .presetn, .cache_req_valid, .cache_req_ready, .cache_req_kind, .route_dma, .route_l2,
    .route_cfg, .l2_req_cpu, .l2_req_dma, .l2_grant_cpu, .l2_grant_dma, .mc_valid, .mc_ready,
    .mc_origin, .mc_src, .mc_cnt, .mc_beats);

// >>> tb/dtrfe_mc_model.sv
// move controller sink that takes queue heads promptly or slowly
module dtrfe_mc_model (
    input  logic pclk,
    input  logic presetn,
    input  logic slow,
    input  logic mc_valid,
    output logic mc_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= 3'h0;
            mc_ready <= 1'b0;
        end else begin
            wait_reg <= wait_reg + 3'h1;
            // slow mode answers one cycle in eight, so heads pile up
            mc_ready <= !slow || wait_reg == 3'h7;
        end
    end
endmodule // dtrfe_mc_model

// >>> tb/testbench.sv
// self-checking bench for the transfer request front end
`include "dtrfe_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, cache_req_valid = 1'b0, master_req_valid = 1'b0;
    logic [2:0]  cache_req_kind = 3'h0;
    logic [31:0] cache_req_src = 32'h0, cache_req_dst = 32'h0;
    logic [31:0] master_req_src = 32'h0, master_req_dst = 32'h0;
    logic [15:0] cache_req_cnt = 16'h0, master_req_cnt = 16'h0;
    logic        cache_req_ready, master_req_ready, route_dma, route_l2, route_cfg;
    logic        l2_req_cpu = 1'b0, l2_req_dma = 1'b0, l2_grant_cpu, l2_grant_dma;
    logic [63:0] chan_event = 64'h0;
    logic        mc_valid, mc_ready, slow = 1'b0;
    logic [1:0]  mc_pri, mc_origin;
    logic [31:0] mc_src, mc_dst;
    logic [15:0] mc_cnt;
    logic [13:0] mc_beats;
    logic [97:0] mq[$];
    int          err_count = 0, checks_done = 0;
    int          chs[3] = '{3, 5, 9};
    logic [31:0] srcs[3] = '{32'h5000, 32'h7000, 32'h9000};
    logic [31:0] ctls[3] = '{32'h0022_0018, 32'h8911_0009, 32'h0013_0004};

    always #20 pclk = ~pclk;

    dtrfe_top u_dtrfe_top (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .cache_req_valid, .cache_req_kind, .cache_req_src, .cache_req_dst, .cache_req_cnt,
        .cache_req_ready, .route_dma, .route_l2, .route_cfg, .l2_req_cpu, .l2_req_dma,
        .l2_grant_cpu, .l2_grant_dma, .chan_event, .master_req_valid, .master_req_src,
        .master_req_dst, .master_req_cnt, .master_req_ready, .mc_valid, .mc_ready, .mc_pri,
        .mc_origin, .mc_src, .mc_dst, .mc_cnt, .mc_beats);
    dtrfe_mc_model u_dtrfe_mc_model (.pclk, .presetn, .slow, .mc_valid, .mc_ready);

    always @(posedge pclk)
        if (mc_valid === 1'b1 && mc_ready === 1'b1)
            mq.push_back({mc_origin, mc_pri, mc_cnt, mc_beats, mc_src, mc_dst});

    task automatic chk(input string n, input logic [97:0] e, input logic [97:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
        chk("slave error", 1'b0, pslverr);
    endtask

    function automatic logic [11:0] ra(input int ch, input int w);
        return 12'(32'h400 + ch * 16 + w * 4);
    endfunction

    // requests carry source, destination and count; destination is the inverted source
    task automatic req(input logic m, input logic [2:0] k, input logic [31:0] s, input logic [15:0] c);
        @(posedge pclk);
        if (m) begin
            master_req_valid <= 1'b1;
            master_req_src <= s;
            master_req_dst <= ~s;
            master_req_cnt <= c;
        end else begin
            cache_req_valid <= 1'b1;
            cache_req_kind <= k;
            cache_req_src <= s;
            cache_req_dst <= ~s;
            cache_req_cnt <= c;
        end
        @(posedge pclk);
        while ((m ? master_req_ready : cache_req_ready) !== 1'b1) @(posedge pclk);
        if (m) master_req_valid <= 1'b0;
        else cache_req_valid <= 1'b0;
    endtask

    task automatic em(input logic [1:0] o, input logic [1:0] p, input logic [15:0] c,
                      input logic [31:0] s);
        logic [97:0] g;
        logic [16:0] b;
        b = ({1'b0, c} + 17'h7) >> 3;
        while (mq.size() == 0) @(posedge pclk);
        g = mq.pop_front();
        chk("mc request", {o, p, c, b[13:0], s, ~s}, g);
    endtask

    task automatic ev(input int ch);
        @(posedge pclk);
        chan_event <= 64'h1 << ch;
        @(posedge pclk);
        chan_event <= 64'h0;
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        $display("watchdog expired");
        stop_test();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        wr(`DTRFE_OFF_CACHE_CFG, 32'h1);
        wr(`DTRFE_OFF_QC_OPT, 32'h2);
        rdc("cache config", `DTRFE_OFF_CACHE_CFG, 32'h1);
        rdc("unmapped", 12'h3f0, 32'h0);
        for (int k = 0; k < 8; k++) begin
            req(1'b0, k[2:0], 32'h1000 + k, 16'(8 * k + 1));
            // route pulse stands one cycle: read it at the edge that ends it
            @(posedge pclk);
            chk("route", k < 5 ? 3'h4 : (k == 6 ? 3'h1 : 3'h2), {route_dma, route_l2, route_cfg});
            if (k < 5) em(2'h0, k == 0 ? 2'h2 : 2'h1, 16'(8 * k + 1), 32'h1000 + k);
        end
        repeat (20) @(posedge pclk);
        chk("local kinds queued", 0, mq.size());
        $display("test cache kinds done");
        wr(`DTRFE_OFF_MASTER_CTL, 32'h3);
        req(1'b1, 3'h0, 32'h2000, 16'h40);
        em(2'h2, 2'h3, 16'h40, 32'h2000);
        slow <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            wr(`DTRFE_OFF_CACHE_CFG, i ? 32'h1 : 32'h3);
            wr(`DTRFE_OFF_MASTER_CTL, i ? 32'h1 : 32'h0);
            fork
                req(1'b0, 3'h1, 32'h3000, 16'h10);
                req(1'b1, 3'h0, 32'h4000, 16'h11);
            join
            em(i ? 2'h0 : 2'h2, i ? 2'h1 : 2'h0, i ? 16'h10 : 16'h11, i ? 32'h3000 : 32'h4000);
            em(i ? 2'h2 : 2'h0, i ? 2'h1 : 2'h3, i ? 16'h11 : 16'h10, i ? 32'h4000 : 32'h3000);
        end
        slow <= 1'b0;
        $display("test arbitration done");
        for (int i = 0; i < 3; i++) begin
            wr(ra(chs[i], 0), srcs[i]);
            wr(ra(chs[i], 1), ~srcs[i]);
            wr(ra(chs[i], 2), ctls[i]);
        end
        ev(3);
        em(2'h1, 2'h2, 16'h18, 32'h5000);
        rdc("syncs left", ra(3, 2), 32'h0021_0018);
        ev(5);
        em(2'h1, 2'h1, 16'h9, 32'h7000);
        rdc("linked source", ra(5, 0), 32'h9000);
        rdc("linked control", ra(5, 2), 32'h0013_0004);
        $display("test channels done");
        for (int w = 0; w < 2; w++) begin
            wr(`DTRFE_OFF_WEIGHT, 32'(w));
            l2_req_cpu <= 1'b1;
            l2_req_dma <= 1'b1;
            repeat (2) @(posedge pclk);
            #1;
            chk("l2 contention", w ? 2'h1 : 2'h2, {l2_grant_cpu, l2_grant_dma});
            @(posedge pclk);
            l2_req_dma <= 1'b0;
            repeat (2) @(posedge pclk);
            #1;
            chk("l2 cpu alone", 2'h2, {l2_grant_cpu, l2_grant_dma});
            @(posedge pclk);
            l2_req_cpu <= 1'b0;
        end
        $display("test l2 weight done");
        rdc("status idle", `DTRFE_OFF_STATUS, 32'h0);
        $display("test status done");
        stop_test();
    end
endmodule // testbench
